// [dtg_pkg.sv]
// constants, field layouts and carrier types of the dual-tone generator
package dtg_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] DTG_IDX_TONE_PAIR_SELECT = 10'h019;
  localparam logic [9:0] DTG_IDX_TONE_OUTPUT_CONTROL = 10'h01a;
  localparam logic [9:0] DTG_IDX_OSC_FREQUENCY_SELECT = 10'h029;
  localparam logic [9:0] DTG_IDX_TONE_STATUS = 10'h030;

  localparam logic [3:0] DTG_RST_TONE_PAIR_SELECT = 4'h0;
  localparam logic [3:0] DTG_RST_TONE_OUTPUT_CONTROL = 4'h0;
  localparam logic [3:0] DTG_RST_OSC_FREQUENCY_SELECT = 4'h0;

  // status register layout
  localparam int DTG_STAT_ROW_SLOT_LSB = 0;
  localparam int DTG_STAT_COL_SLOT_LSB = 5;
  localparam int DTG_STAT_ROW_ACTIVE = 10;
  localparam int DTG_STAT_COL_ACTIVE = 11;
  localparam int DTG_STAT_GEN_ENABLE = 12;

  // one tone period is this many slots
  localparam int DTG_SLOTS = 32;
  localparam logic [10:0] DTG_SLOT_STEP = 11'h020;
  localparam logic [7:0] DTG_SINE_MID = 8'h80;
  localparam logic [8:0] DTG_SINE_FULL = 9'h100;

  // oscillator clock divide ratios per select code 00..11
  localparam logic [3:0][3:0] DTG_PRESCALE_DIV =
    {4'ha, 4'h5, 4'h2, 4'h1};

  // tone periods in prescaled clocks per select code 00..11
  localparam logic [3:0][9:0] DTG_ROW_PERIOD =
    {10'h1aa, 10'h1d6, 10'h208, 10'h240};
  localparam logic [3:0][9:0] DTG_COL_PERIOD =
    {10'h0f4, 10'h10e, 10'h12c, 10'h14a};

  // first quarter of the stepped sine, slots 0..8
  localparam logic [8:0][7:0] DTG_SINE_QUARTER =
    {8'hff, 8'hfd, 8'hf5, 8'hea, 8'hda, 8'hc7, 8'hb1, 8'h99, 8'h80};

  typedef struct packed {
    logic [1:0] col_sel;
    logic [1:0] row_sel;
  } dtg_tone_pair_t;

  typedef struct packed {
    logic column_out_enable;
    logic row_out_enable;
    logic generator_enable;
    logic unused;
  } dtg_out_ctl_t;

  typedef struct packed {
    logic sub_osc_stop_in_stop_mode;
    logic sub_osc_divide_select;
    logic [1:0] osc_freq_sel;
  } dtg_osc_sel_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } dtg_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } dtg_ahb_rsp_t;

endpackage : dtg_pkg

// [dtg_top.sv]
// dual-tone generator with its ahb-lite register slave
// Operation
// R01: tone select bits 3:2 pick column tone 1209/1336/1477/1633 Hz.
// R02: tone select bits 1:0 pick row tone 697/770/852/941 Hz.
// R03: output control is write-only, bit 0 unused, reset clears it.
// R04: bit 3 gates column pin, bit 2 gates row pin, independently.
// R05: bit 1 enables the whole tone generator.
// R06: oscillator clock divided by 1, 2, 5 or 10 per select field.
// R07: software sets frequency select to match the fitted oscillator.
// R08: a mismatched select still divides as programmed, tones shift.
// R09: each tone is a stepped sine of 32 equal slots.
// R10: row and column tones drive separate ladder outputs.
// R11: select bit 2 picks sub-oscillator divide by 8 or by 4.
// R12: select bit 3 decides whether sub-oscillator halts in stop mode.
// R13: select bit 3 is cleared only by reset; the code also loads it from write bit 3 on every frequency select write.
// R14: each tone divider reloads with a period fixed per tone.
// R15: disabled tone holds its counter at slot 0, pin steady.
`timescale 1ns/1ps
`default_nettype none

module dtg_top #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic CLK,
  input wire logic RST,
  input wire dtg_pkg::dtg_ahb_req_t AHB_IN,
  output dtg_pkg::dtg_ahb_rsp_t AHB_OUT,
  output logic [7:0] ROW_TONE_PIN,
  output logic [7:0] COLUMN_TONE_PIN,
  output logic SUB_OSC_DIVIDE_SELECT,
  output logic SUB_OSC_STOP_IN_STOP_MODE
);
  import dtg_pkg::*;

  if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : g_bad_width
    $error("ADDR_WIDTH must lie between 12 and 32");
  end

  function automatic logic [7:0] sine_step(input logic [4:0] slot);
    logic [3:0] j;
    logic [7:0] q;
    j = slot[3:0];
    q = (j <= 4'h8) ? DTG_SINE_QUARTER[j] : DTG_SINE_QUARTER[4'h0 - j];
    if (slot[4]) begin
      sine_step = 8'(DTG_SINE_FULL - {1'b0, q});
    end else begin
      sine_step = q;
    end
  endfunction : sine_step

  function automatic logic [9:0] tone_period(input logic is_col,
                                             input logic [1:0] sel);
    tone_period = is_col ? DTG_COL_PERIOD[sel] : DTG_ROW_PERIOD[sel];
  endfunction : tone_period

  // ---------------- ahb-lite slave ----------------
  dtg_tone_pair_t tone_pair_q;
  dtg_out_ctl_t out_ctl_q;
  dtg_osc_sel_t osc_sel_q;
  logic dphase_wr_q;
  logic [9:0] dphase_idx_q;
  logic [31:0] hrdata_q;
  logic addr_take;
  logic [9:0] addr_idx;
  logic wr_tone_pair;
  logic wr_out_ctl;
  logic wr_osc_sel;
  logic [31:0] status_word;
  logic [1:0] active;
  logic [1:0][4:0] slot_q;

  assign addr_take = AHB_IN.hsel && AHB_IN.htrans[1] && AHB_IN.hready;
  assign addr_idx = AHB_IN.haddr[11:2];
  assign wr_tone_pair = dphase_wr_q &&
                        (dphase_idx_q == DTG_IDX_TONE_PAIR_SELECT);
  assign wr_out_ctl = dphase_wr_q &&
                      (dphase_idx_q == DTG_IDX_TONE_OUTPUT_CONTROL);
  assign wr_osc_sel = dphase_wr_q &&
                      (dphase_idx_q == DTG_IDX_OSC_FREQUENCY_SELECT);

  always_ff @(posedge CLK) begin
    if (RST) begin
      dphase_wr_q <= 1'b0;
      dphase_idx_q <= 10'h000;
    end else begin
      dphase_wr_q <= addr_take && AHB_IN.hwrite;
      dphase_idx_q <= addr_take ? addr_idx : 10'h000;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[DTG_STAT_ROW_SLOT_LSB +: 5] = slot_q[0];
    status_word[DTG_STAT_COL_SLOT_LSB +: 5] = slot_q[1];
    status_word[DTG_STAT_ROW_ACTIVE] = active[0];
    status_word[DTG_STAT_COL_ACTIVE] = active[1];
    status_word[DTG_STAT_GEN_ENABLE] = out_ctl_q.generator_enable;
  end

  // write-only registers read as zero; only the status word answers
  always_ff @(posedge CLK) begin
    if (RST) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_take && !AHB_IN.hwrite &&
                 addr_idx == DTG_IDX_TONE_STATUS) begin
      hrdata_q <= status_word;
    end else begin
      hrdata_q <= 32'h0000_0000;
    end
  end

  assign AHB_OUT.hrdata = hrdata_q;
  assign AHB_OUT.hreadyout = 1'b1;
  assign AHB_OUT.hresp = 1'b0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      tone_pair_q <= dtg_tone_pair_t'(DTG_RST_TONE_PAIR_SELECT);
    end else if (wr_tone_pair) begin
      tone_pair_q <= dtg_tone_pair_t'(AHB_IN.hwdata[3:0]); // see R01 R02
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      out_ctl_q <= dtg_out_ctl_t'(DTG_RST_TONE_OUTPUT_CONTROL); // see R03
    end else if (wr_out_ctl) begin
      out_ctl_q <= dtg_out_ctl_t'({AHB_IN.hwdata[3:1], 1'b0}); // see R03
    end
  end

  // bit 3 only ever changes by reset or by a software write
  always_ff @(posedge CLK) begin
    if (RST) begin
      osc_sel_q <= dtg_osc_sel_t'(DTG_RST_OSC_FREQUENCY_SELECT); // see R13
    end else if (wr_osc_sel) begin
      osc_sel_q <= dtg_osc_sel_t'(AHB_IN.hwdata[3:0]);
    end
  end

  assign SUB_OSC_DIVIDE_SELECT = osc_sel_q.sub_osc_divide_select; // see R11
  assign SUB_OSC_STOP_IN_STOP_MODE =
    osc_sel_q.sub_osc_stop_in_stop_mode; // see R12

  // ---------------- prescaler ----------------
  logic [3:0] pre_cnt_q;
  logic tone_tick;
  logic [3:0] pre_div;

  // divides as programmed whatever the real oscillator is
  assign pre_div = DTG_PRESCALE_DIV[osc_sel_q.osc_freq_sel]; // see R06 R08
  assign tone_tick = out_ctl_q.generator_enable &&
                     (pre_cnt_q >= pre_div - 4'h1); // see R05

  always_ff @(posedge CLK) begin
    if (RST) begin
      pre_cnt_q <= 4'h0;
    end else if (!out_ctl_q.generator_enable || tone_tick) begin
      pre_cnt_q <= 4'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 4'h1;
    end
  end

  // ---------------- tone channels: 0 row, 1 column ----------------
  logic [1:0][9:0] acc_q;
  logic [1:0][9:0] period;
  logic [1:0] step;
  logic [1:0][10:0] acc_sum;
  logic [1:0][7:0] pin_q;

  assign active[0] = out_ctl_q.generator_enable &&
                     out_ctl_q.row_out_enable; // see R04 R05
  assign active[1] = out_ctl_q.generator_enable &&
                     out_ctl_q.column_out_enable; // see R04 R05
  assign period[0] = tone_period(1'b0, tone_pair_q.row_sel); // see R02
  assign period[1] = tone_period(1'b1, tone_pair_q.col_sel); // see R01

  // fractional divider: 32 slot steps per period clocks on average
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      acc_sum[ch] = {1'b0, acc_q[ch]} + DTG_SLOT_STEP;
      step[ch] = tone_tick && active[ch] &&
                 (acc_sum[ch] >= {1'b0, period[ch]}); // see R14
    end
  end

  always_ff @(posedge CLK) begin
    for (int ch = 0; ch < 2; ch++) begin
      // a new tone restarts its remainder below the new period
      if (RST || !active[ch] || wr_tone_pair) begin
        acc_q[ch] <= 10'h000; // see R14 R15
      end else if (step[ch]) begin
        acc_q[ch] <= 10'(acc_sum[ch] - {1'b0, period[ch]}); // see R14
      end else if (tone_tick) begin
        acc_q[ch] <= acc_sum[ch][9:0];
      end
    end
  end

  always_ff @(posedge CLK) begin
    for (int ch = 0; ch < 2; ch++) begin
      if (RST || !active[ch]) begin
        slot_q[ch] <= 5'h00; // see R15
      end else if (step[ch]) begin
        slot_q[ch] <= slot_q[ch] + 5'h01; // see R09
      end
    end
  end

  always_ff @(posedge CLK) begin
    for (int ch = 0; ch < 2; ch++) begin
      if (RST) begin
        pin_q[ch] <= DTG_SINE_MID;
      end else begin
        pin_q[ch] <= sine_step(slot_q[ch]); // see R09
      end
    end
  end

  assign ROW_TONE_PIN = pin_q[0]; // see R10
  assign COLUMN_TONE_PIN = pin_q[1]; // see R10

  // ---------------- assertions ----------------
  column_select_a: assert property ( // see R01
    @(posedge CLK) disable iff (RST)
    wr_tone_pair |=> tone_pair_q.col_sel == $past(AHB_IN.hwdata[3:2]))
    else $error("column select not taken from bits 3:2");

  row_select_a: assert property ( // see R02
    @(posedge CLK) disable iff (RST)
    wr_tone_pair |=> period[0] ==
      DTG_ROW_PERIOD[$past(AHB_IN.hwdata[1:0])])
    else $error("row period not set from bits 1:0");

  control_reset_a: assert property ( // see R03
    @(posedge CLK)
    RST |=> out_ctl_q == 4'h0 && !active[0] && !active[1])
    else $error("output control not cleared by reset");

  row_gate_a: assert property ( // see R04
    @(posedge CLK) disable iff (RST)
    (!active[0]) [*3] |-> ROW_TONE_PIN == DTG_SINE_MID)
    else $error("row pin moves while row output is off");

  generator_off_a: assert property ( // see R05
    @(posedge CLK) disable iff (RST)
    !out_ctl_q.generator_enable |-> !tone_tick ##1
      (pre_cnt_q == 4'h0 && slot_q[0] == 5'h00 && slot_q[1] == 5'h00))
    else $error("tone logic runs while generator is off");

  prescale_ten_a: assert property ( // see R06
    @(posedge CLK) disable iff (RST)
    tone_tick && osc_sel_q.osc_freq_sel == 2'b11 |-> pre_cnt_q == 4'h9)
    else $error("divide by ten ticks off count");

  slot_advance_a: assert property ( // see R09
    @(posedge CLK) disable iff (RST)
    step[1] |=> slot_q[1] == 5'($past(slot_q[1]) + 5'h01))
    else $error("column slot counter did not advance by one");

  divider_bound_a: assert property ( // see R14
    @(posedge CLK) disable iff (RST)
    acc_q[0] < period[0] && acc_q[1] < period[1])
    else $error("tone divider remainder exceeds period");

  column_hold_a: assert property ( // see R15
    @(posedge CLK) disable iff (RST)
    (!active[1]) [*4] |-> $stable(COLUMN_TONE_PIN) &&
      slot_q[1] == 5'h00)
    else $error("column tone moves while disabled");

  stop_bit_hold_a: assert property ( // see R13
    @(posedge CLK) disable iff (RST)
    !wr_osc_sel |=> $stable(SUB_OSC_STOP_IN_STOP_MODE))
    else $error("stop-mode bit changed without a write");

  sub_divide_a: assert property ( // see R11
    @(posedge CLK) disable iff (RST)
    wr_osc_sel |=> SUB_OSC_DIVIDE_SELECT == $past(AHB_IN.hwdata[2]))
    else $error("sub-oscillator divide bit not taken from bit 2");

  // a tone is heard only while generator and its own gate are both set
  row_hold_a: assert property ( // see R15
    @(posedge CLK) disable iff (RST)
    (!active[0]) [*4] |-> $stable(ROW_TONE_PIN) && slot_q[0] == 5'h00)
    else $error("row tone moves while disabled");

  column_gate_a: assert property ( // see R04
    @(posedge CLK) disable iff (RST)
    (!active[1]) [*3] |-> COLUMN_TONE_PIN == DTG_SINE_MID)
    else $error("column pin moves while column output is off");

  control_fields_a: assert property ( // see R04
    @(posedge CLK) disable iff (RST)
    wr_out_ctl |=> !out_ctl_q.unused &&
      out_ctl_q.column_out_enable == $past(AHB_IN.hwdata[3]) &&
      out_ctl_q.row_out_enable == $past(AHB_IN.hwdata[2]))
    else $error("output gates not taken from bits 3 and 2");

  // first tick after a select change may come early; skip that cycle
  prescale_five_a: assert property ( // see R06
    @(posedge CLK) disable iff (RST)
    tone_tick && osc_sel_q.osc_freq_sel == 2'b10 &&
      $stable(osc_sel_q.osc_freq_sel) |-> pre_cnt_q == 4'h4)
    else $error("divide by five ticks off count");

  prescale_two_a: assert property ( // see R06
    @(posedge CLK) disable iff (RST)
    tone_tick && osc_sel_q.osc_freq_sel == 2'b01 &&
      $stable(osc_sel_q.osc_freq_sel) |-> pre_cnt_q == 4'h1)
    else $error("divide by two ticks off count");

  prescale_one_a: assert property ( // see R06
    @(posedge CLK) disable iff (RST)
    out_ctl_q.generator_enable && osc_sel_q.osc_freq_sel == 2'b00 |->
      tone_tick)
    else $error("undivided clock does not tick every cycle");

  stop_bit_write_a: assert property ( // see R12
    @(posedge CLK) disable iff (RST)
    wr_osc_sel |=> SUB_OSC_STOP_IN_STOP_MODE == $past(AHB_IN.hwdata[3]))
    else $error("stop-mode bit not taken from bit 3");

  // write-only registers and holes read back as zero
  read_zero_a: assert property ( // see R03
    @(posedge CLK) disable iff (RST)
    addr_take && !AHB_IN.hwrite && addr_idx != DTG_IDX_TONE_STATUS |=>
      AHB_OUT.hrdata == 32'h0000_0000)
    else $error("write-only register returned data");

  status_read_a: assert property ( // see R05
    @(posedge CLK) disable iff (RST)
    addr_take && !AHB_IN.hwrite && addr_idx == DTG_IDX_TONE_STATUS |=>
      AHB_OUT.hrdata[DTG_STAT_GEN_ENABLE] ==
      $past(out_ctl_q.generator_enable))
    else $error("status read does not show generator enable");

endmodule : dtg_top

`default_nettype wire

// [dtg_line_model.sv]
// telephone line model that counts tone steps on both ladder outputs
`timescale 1ns/1ps
`default_nettype none

module dtg_line_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic [7:0] row_tone,
  input wire logic [7:0] col_tone,
  output logic [15:0] row_steps,
  output logic [15:0] col_steps
);
  logic [7:0] row_last;
  logic [7:0] col_last;

  // each ladder heard on its own pair of wires
  always_ff @(posedge clk) begin
    row_last <= row_tone;
    col_last <= col_tone;
    if (clr) begin
      row_steps <= 16'h0000;
      col_steps <= 16'h0000;
    end else begin
      // every slot step changes the ladder code
      if (row_tone !== row_last) row_steps <= row_steps + 16'h0001;
      if (col_tone !== col_last) col_steps <= col_steps + 16'h0001;
    end
  end
endmodule : dtg_line_model

`default_nettype wire

// [tb_top.sv]
// self-checking bench of the dual-tone generator
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dtg_pkg::*;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  dtg_ahb_req_t req = '0;
  dtg_ahb_req_t ahb_in;
  dtg_ahb_rsp_t rsp;
  logic [7:0] row_pin;
  logic [7:0] col_pin;
  logic sub_div;
  logic sub_stop;
  logic [15:0] row_steps;
  logic [15:0] col_steps;
  logic [31:0] rd;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int win;
  // osc select, tone pair, control, row steps, column steps per window
  logic [27:0] cases [7] = '{28'h00e2037, 28'h15e2037, 28'h2ae2037,
    28'h3fe2037, 28'h0562000, 28'h05a0037, 28'h05c0000};

  always #50 clk = ~clk;

  always_comb begin
    ahb_in = req;
    ahb_in.hready = rsp.hreadyout;
  end

  dtg_top dtg_top_i (.CLK(clk), .RST(rst), .AHB_IN(ahb_in), .AHB_OUT(rsp),
    .ROW_TONE_PIN(row_pin), .COLUMN_TONE_PIN(col_pin),
    .SUB_OSC_DIVIDE_SELECT(sub_div), .SUB_OSC_STOP_IN_STOP_MODE(sub_stop));

  dtg_line_model dtg_line_model_i (.clk(clk), .clr(clr), .row_tone(row_pin),
    .col_tone(col_pin), .row_steps(row_steps), .col_steps(col_steps));

  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // step counts may slip by one with the window phase
  task automatic chk_near(input logic [15:0] got, input logic [7:0] exp);
    samples_checked++;
    if ($isunknown(got) || got > {8'h00, exp} + 16'h0001 ||
        got + 16'h0001 < {8'h00, exp} ||
        (exp == 8'h00 && got != 16'h0000)) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_near

  task automatic ahb(input logic wr, input logic [9:0] idx,
      input logic [3:0] wd);
    @(posedge clk);
    req.hsel <= 1'b1;
    req.haddr <= {20'h00000, idx, 2'b00};
    req.htrans <= 2'b10;
    req.hwrite <= wr;
    req.hsize <= 3'b010;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= {28'h0000000, wd};
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
    chk({31'h0, rsp.hresp}, 32'h0);
  endtask : ahb

  task automatic listen(input int n);
    repeat (3) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : listen

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({16'h0, row_pin, col_pin}, 32'h8080);
    chk({30'h0, sub_stop, sub_div}, 32'h0);
    // software changes the select on one fixed clock; each row's window scales with its divide ratio
    for (int i = 0; i < 7; i++) begin
      ahb(1'b1, DTG_IDX_OSC_FREQUENCY_SELECT, cases[i][27:24]);
      ahb(1'b1, DTG_IDX_TONE_PAIR_SELECT, cases[i][23:20]);
      ahb(1'b1, DTG_IDX_TONE_OUTPUT_CONTROL, cases[i][19:16]);
      win = DTG_ROW_PERIOD[cases[i][21:20]] *
            DTG_PRESCALE_DIV[cases[i][25:24]];
      listen(win);
      chk_near(row_steps, cases[i][15:8]);
      chk_near(col_steps, cases[i][7:0]);
    end
    ahb(1'b1, DTG_IDX_TONE_OUTPUT_CONTROL, 4'he);
    ahb(1'b0, DTG_IDX_TONE_STATUS, 4'h0);
    chk({29'h0, rd[12:10]}, 32'h7);
    ahb(1'b0, DTG_IDX_TONE_OUTPUT_CONTROL, 4'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 10'h0ff, 4'h0);
    chk(rd, 32'h0);
    // only the unused bit set: everything stops mid-tone
    ahb(1'b1, DTG_IDX_TONE_OUTPUT_CONTROL, 4'h1);
    listen(600);
    chk({16'h0, row_pin, col_pin}, 32'h8080);
    chk_near(row_steps, 8'h00);
    ahb(1'b1, DTG_IDX_OSC_FREQUENCY_SELECT, 4'h4);
    @(negedge clk);
    chk({30'h0, sub_stop, sub_div}, 32'h1);
    ahb(1'b1, DTG_IDX_OSC_FREQUENCY_SELECT, 4'hc);
    ahb(1'b1, DTG_IDX_TONE_PAIR_SELECT, 4'h3);
    @(negedge clk);
    chk({30'h0, sub_stop, sub_div}, 32'h3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({30'h0, sub_stop, sub_div}, 32'h0);
    chk({16'h0, row_pin, col_pin}, 32'h8080);
    report_and_stop();
  end
endmodule : tb_top

`default_nettype wire
